// *** rtl/bebt_top.sv ***
// Event detection, break and timing logic watching an emulated MCU bus.
// Assumes the bus cycle signals are synchronous to pclk with one
// bus_valid pulse per bus cycle; probe pins are asynchronous.
`timescale 1ns/1ps

// Contract
// - A channel can match a bus address inside a programmed range, a single address included.
// - A channel can accept only reads, only writes or either direction.
// - A channel can compare bus data with a pattern, ignoring bits cleared in the mask.
// - A channel can require a given access type such as transfer-controller or prefetch.
// - A channel can require a given access area such as on-chip ROM or RAM.
// - A channel can require chosen levels on any subset of the four probe inputs.
// - A channel can postpone its trigger by a programmed number of bus cycles.
// - Execution halts when a selected event or ordered sequence of events becomes active.
// - The halt can be deferred by up to 65535 bus cycles.
// - Elapsed time is measured from a first event to a second event.
// - The level probe input is an event condition, matching low or high as software selects.
// - The trigger probe output goes high when any of the four monitor settings matches.
module bebt_top (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic [bebt_pkg::PA_W-1:0]   paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output logic                             pready,
	output logic [31:0]                      prdata,
	output logic                             pslverr,
	input  wire logic                        bus_valid,
	input  wire logic [bebt_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic                        bus_write,
	input  wire logic [bebt_pkg::DATA_W-1:0] bus_data,
	input  wire logic [1:0]                  bus_type,
	input  wire logic [1:0]                  bus_area,
	input  wire logic [bebt_pkg::NPRB-1:0]   probe_in,
	input  wire logic                        level_condition_probe_in,
	output logic                             monitor_trigger_probe_out,
	output logic                             break_req
);
	import bebt_pkg::*;

	logic [ADDR_W-1:0] ch_lo_ff  [NCH];
	logic [ADDR_W-1:0] ch_hi_ff  [NCH];
	logic [DATA_W-1:0] ch_dat_ff [NCH];
	logic [DATA_W-1:0] ch_msk_ff [NCH];
	logic [CFG_W-1:0]  ch_cfg_ff [NCH];
	logic [DLY_W-1:0]  ch_dly_ff [NCH];
	logic [31:0]       mon_ff    [NMON];
	logic [CTRL_W-1:0] ctrl_ff;
	logic [DLY_W-1:0]  bdly_ff;
	logic [3:0]        tsel_ff;
	logic [NPRB:0]     prb_s1_ff;
	logic [NPRB:0]     prb_s2_ff;
	logic [NCH-1:0]    ch_hit;
	logic [NCH-1:0]    ch_trig;
	logic [NMON-1:0]   mon_hit;
	logic              lvl_hit;
	logic              wr_en;
	logic              setup;
	logic              sel_ch;
	logic              sel_mon;
	logic [1:0]        ch_idx;
	logic [2:0]        ch_reg;
	logic [1:0]        mon_idx;
	logic              dec_ok;
	logic [31:0]       rd_mux;
	logic [31:0]       prdata_ff;
	logic              pslverr_ff;
	logic [1:0]        stage_ff;
	logic              brk_fire;
	logic [DLY_W-1:0]  bcnt_ff;
	logic              bbusy_ff;
	logic              halted_ff;
	logic              halt_set;
	logic              halt_clr;
	logic              mon_out_ff;
	bebt_tmr_e         tmr_ff;
	logic [TMR_W-1:0]  tmr_cnt_ff;
	logic              tmr_start;
	logic              tmr_stop;

	// ----------------------------------------------------------------
	// Probe synchronisers
	// ----------------------------------------------------------------
	// Pins come from the user system, so two flops before any use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prb_s1_ff <= '0;
			prb_s2_ff <= '0;
		end else begin
			prb_s1_ff <= {level_condition_probe_in, probe_in};
			prb_s2_ff <= prb_s1_ff;
		end
	end

	// Software picks which level of the probe counts as a match
	assign lvl_hit = prb_s2_ff[NPRB] == ctrl_ff[CTRL_LVL_POL];

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite && dec_ok;
	assign sel_ch  = paddr[PA_W-1:7] == CH_BASE[PA_W-1:7];
	assign sel_mon = (paddr & 12'hFF0) == MON_BASE;
	assign ch_idx  = paddr[6:5];
	assign ch_reg  = paddr[4:2];
	assign mon_idx = paddr[3:2];

	always_comb begin
		dec_ok = 1'b1;
		rd_mux = RST_WORD;
		if (paddr[1:0] != 2'h0) begin
			dec_ok = 1'b0;
		end else if (sel_ch) begin
			unique case (ch_reg)
				CH_LO:   rd_mux = 32'(ch_lo_ff[ch_idx]);
				CH_HI:   rd_mux = 32'(ch_hi_ff[ch_idx]);
				CH_DAT:  rd_mux = 32'(ch_dat_ff[ch_idx]);
				CH_MSK:  rd_mux = 32'(ch_msk_ff[ch_idx]);
				CH_CFG:  rd_mux = 32'(ch_cfg_ff[ch_idx]);
				CH_DLY:  rd_mux = 32'(ch_dly_ff[ch_idx]);
				default: dec_ok = 1'b0;
			endcase
		end else if (sel_mon) begin
			rd_mux = mon_ff[mon_idx];
		end else begin
			unique case (paddr)
				REG_CTRL: rd_mux = 32'(ctrl_ff);
				REG_BDLY: rd_mux = 32'(bdly_ff);
				REG_STAT: begin
					rd_mux[STAT_HALTED]        = halted_ff;
					rd_mux[STAT_BDLY]          = bbusy_ff;
					rd_mux[STAT_TRUN]          = tmr_ff == TMR_RUN;
					rd_mux[STAT_TDONE]         = tmr_ff == TMR_DONE;
					rd_mux[STAT_SEQ_LSB +: 2]  = stage_ff;
				end
				REG_TMR:  rd_mux = tmr_cnt_ff;
				REG_TSEL: rd_mux = 32'(tsel_ff);
				default:  dec_ok = 1'b0;
			endcase
		end
	end

	// Read data and error are fetched in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= RST_WORD;
			pslverr_ff <= 1'b0;
		end else if (setup) begin
			prdata_ff  <= pwrite ? RST_WORD : rd_mux;
			pslverr_ff <= !dec_ok;
		end else if (psel && penable) begin
			pslverr_ff <= 1'b0;
		end
	end

	// No wait states
	assign pready  = 1'b1;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NCH; i++) begin
				ch_lo_ff[i]  <= '0;
				ch_hi_ff[i]  <= '0;
				ch_dat_ff[i] <= '0;
				ch_msk_ff[i] <= '0;
				ch_cfg_ff[i] <= '0;
				ch_dly_ff[i] <= '0;
			end
		end else if (wr_en && sel_ch) begin
			unique case (ch_reg)
				CH_LO:   ch_lo_ff[ch_idx]  <= pwdata[ADDR_W-1:0];
				CH_HI:   ch_hi_ff[ch_idx]  <= pwdata[ADDR_W-1:0];
				CH_DAT:  ch_dat_ff[ch_idx] <= pwdata[DATA_W-1:0];
				CH_MSK:  ch_msk_ff[ch_idx] <= pwdata[DATA_W-1:0];
				CH_CFG:  ch_cfg_ff[ch_idx] <= pwdata[CFG_W-1:0];
				CH_DLY:  ch_dly_ff[ch_idx] <= pwdata[DLY_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NMON; i++) begin
				mon_ff[i] <= RST_WORD;
			end
		end else if (wr_en && sel_mon) begin
			mon_ff[mon_idx] <= pwdata;
		end
	end

	// Halt clear bit is a strobe and is not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= '0;
			bdly_ff <= '0;
			tsel_ff <= '0;
		end else if (wr_en && !sel_ch && !sel_mon) begin
			if (paddr == REG_CTRL) begin
				ctrl_ff <= pwdata[CTRL_W-1:0] & ~(10'h001 << CTRL_HALT_CLR);
			end
			if (paddr == REG_BDLY) begin
				bdly_ff <= pwdata[DLY_W-1:0];
			end
			if (paddr == REG_TSEL) begin
				tsel_ff <= pwdata[3:0];
			end
		end
	end

	assign halt_clr = wr_en && paddr == REG_CTRL && pwdata[CTRL_HALT_CLR];

	// ----------------------------------------------------------------
	// Range channels
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		bebt_range_chan u_chan (
			.pclk      (pclk),
			.presetn   (presetn),
			.bus_valid (bus_valid),
			.bus_addr  (bus_addr),
			.bus_write (bus_write),
			.bus_data  (bus_data),
			.bus_type  (bus_type),
			.bus_area  (bus_area),
			.probe_lvl (prb_s2_ff[NPRB-1:0]),
			.lvl_hit   (lvl_hit),
			.addr_lo   (ch_lo_ff[g]),
			.addr_hi   (ch_hi_ff[g]),
			.data_val  (ch_dat_ff[g]),
			.data_mask (ch_msk_ff[g]),
			.cfg       (ch_cfg_ff[g]),
			.dly       (ch_dly_ff[g]),
			.hit       (ch_hit[g]),
			.trig      (ch_trig[g])
		);
	end

	// ----------------------------------------------------------------
	// Break sequencing
	// ----------------------------------------------------------------
	// Sequence runs channel 0 upward to the programmed last stage
	always_comb begin
		if (ctrl_ff[CTRL_SEQ_EN]) begin
			brk_fire = ch_trig[stage_ff] && stage_ff == ctrl_ff[CTRL_SEQ_LSB +: 2];
		end else begin
			brk_fire = |(ch_trig & ctrl_ff[CTRL_BRK_LSB +: NCH]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_ff <= '0;
		end else if (!ctrl_ff[CTRL_SEQ_EN]) begin
			stage_ff <= '0;
		end else if (ch_trig[stage_ff]) begin
			stage_ff <= brk_fire ? 2'h0 : stage_ff + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// Break delay and halt request
	// ----------------------------------------------------------------
	// A fire during a running delay is dropped; the first one wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcnt_ff  <= '0;
			bbusy_ff <= 1'b0;
		end else if (bbusy_ff) begin
			if (bus_valid) begin
				bcnt_ff <= bcnt_ff - 16'h0001;
				if (bcnt_ff == 16'h0001) begin
					bbusy_ff <= 1'b0;
				end
			end
		end else if (brk_fire && bdly_ff != '0) begin
			bcnt_ff  <= bdly_ff;
			bbusy_ff <= 1'b1;
		end
	end

	assign halt_set = (brk_fire && !bbusy_ff && bdly_ff == '0) ||
	                  (bbusy_ff && bus_valid && bcnt_ff == 16'h0001);

	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halted_ff <= 1'b0;
		end else if (halt_set) begin
			halted_ff <= 1'b1;
		end else if (halt_clr) begin
			halted_ff <= 1'b0;
		end
	end

	assign break_req = halted_ff;

	// ----------------------------------------------------------------
	// Execution timer
	// ----------------------------------------------------------------
	assign tmr_start = ch_trig[tsel_ff[1:0]];
	assign tmr_stop  = ch_trig[tsel_ff[TSEL_STOP_LSB-2 +: 2]];

	// Counts pclk cycles; clearing the enable rearms it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_ff     <= TMR_IDLE;
			tmr_cnt_ff <= '0;
		end else if (!ctrl_ff[CTRL_TMR_EN]) begin
			tmr_ff <= TMR_IDLE;
		end else begin
			unique case (tmr_ff)
				TMR_IDLE: begin
					if (tmr_start) begin
						tmr_ff     <= TMR_RUN;
						tmr_cnt_ff <= '0;
					end
				end
				TMR_RUN: begin
					tmr_cnt_ff <= tmr_cnt_ff + 32'h0000_0001;
					if (tmr_stop) begin
						tmr_ff <= TMR_DONE;
					end
				end
				TMR_DONE: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Bus monitor trigger probe
	// ----------------------------------------------------------------
	for (genvar m = 0; m < NMON; m++) begin : g_mon
		assign mon_hit[m] = mon_ff[m][MON_EN_BIT] && bus_addr == mon_ff[m][ADDR_W-1:0];
	end

	// One pclk high per matching bus cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mon_out_ff <= 1'b0;
		end else begin
			mon_out_ff <= bus_valid && |mon_hit;
		end
	end

	assign monitor_trigger_probe_out = mon_out_ff;

endmodule : bebt_top

// *** rtl/bebt_pkg.sv ***
// Shared constants of the bus event and break trigger block.
// Assumes a 32-bit APB slave port and a single pclk domain.

package bebt_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int NCH    = 4;
	localparam int NMON   = 4;
	localparam int NPRB   = 4;
	localparam int DLY_W  = 16;
	localparam int TMR_W  = 32;
	localparam int PA_W   = 12;

	// Longest break postponement in bus cycles
	localparam logic [DLY_W-1:0] BDLY_MAX = 16'hFFFF;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [PA_W-1:0] REG_CTRL = 12'h000;
	localparam logic [PA_W-1:0] REG_BDLY = 12'h004;
	localparam logic [PA_W-1:0] REG_STAT = 12'h008;
	localparam logic [PA_W-1:0] REG_TMR  = 12'h00C;
	localparam logic [PA_W-1:0] REG_TSEL = 12'h010;
	localparam logic [PA_W-1:0] MON_BASE = 12'h040;
	localparam logic [PA_W-1:0] CH_BASE  = 12'h080;
	localparam logic [2:0]      CH_LO    = 3'h0;
	localparam logic [2:0]      CH_HI    = 3'h1;
	localparam logic [2:0]      CH_DAT   = 3'h2;
	localparam logic [2:0]      CH_MSK   = 3'h3;
	localparam logic [2:0]      CH_CFG   = 3'h4;
	localparam logic [2:0]      CH_DLY   = 3'h5;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_BRK_LSB  = 0;
	localparam int CTRL_SEQ_EN   = 4;
	localparam int CTRL_SEQ_LSB  = 5;
	localparam int CTRL_LVL_POL  = 7;
	localparam int CTRL_HALT_CLR = 8;
	localparam int CTRL_TMR_EN   = 9;
	localparam int CTRL_W        = 10;
	localparam int TSEL_STOP_LSB = 4;
	localparam int MON_EN_BIT    = 31;
	localparam int CFG_DIR_LSB   = 0;
	localparam int CFG_DATA_EN   = 2;
	localparam int CFG_TYPE_EN   = 3;
	localparam int CFG_TYPE_LSB  = 4;
	localparam int CFG_AREA_EN   = 6;
	localparam int CFG_AREA_LSB  = 7;
	localparam int CFG_PEN_LSB   = 9;
	localparam int CFG_PVAL_LSB  = 13;
	localparam int CFG_LVL_EN    = 17;
	localparam int CFG_ADDR_EN   = 18;
	localparam int CFG_CH_EN     = 19;
	localparam int CFG_W         = 20;
	localparam int STAT_HALTED   = 0;
	localparam int STAT_BDLY     = 1;
	localparam int STAT_TRUN     = 2;
	localparam int STAT_TDONE    = 3;
	localparam int STAT_SEQ_LSB  = 4;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]  DIR_ANY  = 2'h0;
	localparam logic [1:0]  DIR_RD   = 2'h1;
	localparam logic [1:0]  DIR_WR   = 2'h2;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {TMR_IDLE, TMR_RUN, TMR_DONE} bebt_tmr_e;

endpackage : bebt_pkg

// *** rtl/bebt_range_chan.sv ***
// One range channel: qualifier match and postponed trigger.
// Assumes bus signals and probe levels already sit in the pclk domain.
`timescale 1ns/1ps

module bebt_range_chan (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        bus_valid,
	input  wire logic [bebt_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic                        bus_write,
	input  wire logic [bebt_pkg::DATA_W-1:0] bus_data,
	input  wire logic [1:0]                  bus_type,
	input  wire logic [1:0]                  bus_area,
	input  wire logic [bebt_pkg::NPRB-1:0]   probe_lvl,
	input  wire logic                        lvl_hit,
	input  wire logic [bebt_pkg::ADDR_W-1:0] addr_lo,
	input  wire logic [bebt_pkg::ADDR_W-1:0] addr_hi,
	input  wire logic [bebt_pkg::DATA_W-1:0] data_val,
	input  wire logic [bebt_pkg::DATA_W-1:0] data_mask,
	input  wire logic [bebt_pkg::CFG_W-1:0]  cfg,
	input  wire logic [bebt_pkg::DLY_W-1:0]  dly,
	output logic                             hit,
	output logic                             trig
);
	import bebt_pkg::*;

	logic             addr_ok;
	logic             dir_ok;
	logic             data_ok;
	logic             type_ok;
	logic             area_ok;
	logic             probe_ok;
	logic             lvl_ok;
	logic [1:0]       dir;
	logic [NPRB-1:0]  pen;
	logic [NPRB-1:0]  pval;
	logic [DLY_W-1:0] cnt_ff;
	logic             busy_ff;
	logic             trig_ff;

	// ----------------------------------------------------------------
	// Qualifiers
	// ----------------------------------------------------------------
	assign dir  = cfg[CFG_DIR_LSB +: 2];
	assign pen  = cfg[CFG_PEN_LSB +: NPRB];
	assign pval = cfg[CFG_PVAL_LSB +: NPRB];

	assign addr_ok  = !cfg[CFG_ADDR_EN] || (bus_addr >= addr_lo && bus_addr <= addr_hi);
	assign dir_ok   = (dir == DIR_ANY) || (dir == DIR_RD && !bus_write) ||
	                  (dir == DIR_WR && bus_write);
	assign data_ok  = !cfg[CFG_DATA_EN] || (((bus_data ^ data_val) & data_mask) == '0);
	assign type_ok  = !cfg[CFG_TYPE_EN] || (bus_type == cfg[CFG_TYPE_LSB +: 2]);
	assign area_ok  = !cfg[CFG_AREA_EN] || (bus_area == cfg[CFG_AREA_LSB +: 2]);
	assign probe_ok = &((probe_lvl ~^ pval) | ~pen);
	assign lvl_ok   = !cfg[CFG_LVL_EN] || lvl_hit;

	// All enabled qualifiers on the same bus cycle
	assign hit = cfg[CFG_CH_EN] && bus_valid && addr_ok && dir_ok && data_ok &&
	             type_ok && area_ok && probe_ok && lvl_ok;

	// ----------------------------------------------------------------
	// Postponed trigger, counted in bus cycles
	// ----------------------------------------------------------------
	// New hits while counting are ignored, not queued
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff  <= '0;
			busy_ff <= 1'b0;
			trig_ff <= 1'b0;
		end else begin
			trig_ff <= 1'b0;
			if (bus_valid && busy_ff) begin
				if (cnt_ff == 16'h0001) begin
					busy_ff <= 1'b0;
					trig_ff <= 1'b1;
				end
				cnt_ff <= cnt_ff - 16'h0001;
			end else if (hit) begin
				if (dly == '0) begin
					trig_ff <= 1'b1;
				end else begin
					cnt_ff  <= dly;
					busy_ff <= 1'b1;
				end
			end
		end
	end

	assign trig = trig_ff;

endmodule : bebt_range_chan

// *** sim/bebt_top_properties.sv ***
// Port checker for bebt_top.
// Assumes one pclk domain; bound onto every bebt_top.
`timescale 1ns/1ps

module bebt_chk (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic [bebt_pkg::PA_W-1:0] paddr,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [31:0]               pwdata,
	input wire logic                      pready,
	input wire logic [31:0]               prdata,
	input wire logic                      pslverr,
	input wire logic                      bus_valid,
	input wire logic                      monitor_trigger_probe_out,
	input wire logic                      break_req
);
	import bebt_pkg::*;
	// Halt clear strobe, taken at the access edge
	wire logic clr_wr = psel && penable && pwrite && paddr == REG_CTRL && pwdata[CTRL_HALT_CLR];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// Halt output
	// ----
	AST_HALT_HOLD: assert property (break_req && !clr_wr |=> break_req)
		else $error("halt dropped without clear");
	AST_HALT_CLR: assert property ($fell(break_req) |-> $past(clr_wr))
		else $error("halt fell without clear write");
	AST_HALT_CAUSE: assert property ($rose(break_req) |->
		$past(bus_valid) || $past(bus_valid, 2))
		else $error("halt rose with no bus cycle behind it");
	// ----
	// Monitor pulse
	// ----
	AST_MON_CAUSE: assert property (monitor_trigger_probe_out |-> $past(bus_valid))
		else $error("monitor pulse without bus cycle");
	AST_MON_WIDTH: assert property (!bus_valid |=> !monitor_trigger_probe_out)
		else $error("monitor pulse too long");
	// ----
	// Register port
	// ----
	AST_PREADY: assert property (pready)
		else $error("pready low");
	AST_WR_ZERO: assert property (psel && !penable && pwrite |=> prdata == 32'h0)
		else $error("read data not zero on write");
	AST_ERR_BAD: assert property (psel && !penable &&
		(paddr[1:0] != 2'h0 || paddr == 12'h098 || paddr == 12'h180) |=> pslverr)
		else $error("bad address not refused");
	AST_ERR_OK: assert property (psel && !penable && paddr == REG_CTRL |=> !pslverr)
		else $error("good address refused");
	AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
endmodule : bebt_chk

bind bebt_top bebt_chk bebt_chk_b (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .bus_valid(bus_valid), .break_req(break_req),
	.monitor_trigger_probe_out(monitor_trigger_probe_out));

// *** sim/bebt_mcu_model.sv ***
// Emulated MCU bus and probe pins feeding bebt_top.
// Assumes pclk from the bench, which calls the tasks hierarchically.
`timescale 1ns/1ps

module bebt_mcu_model (
	input  wire logic                        pclk,
	output logic                             bus_valid,
	output logic [bebt_pkg::ADDR_W-1:0]      bus_addr,
	output logic                             bus_write,
	output logic [bebt_pkg::DATA_W-1:0]      bus_data,
	output logic [1:0]                       bus_type,
	output logic [1:0]                       bus_area,
	output logic [bebt_pkg::NPRB-1:0]        probe_in,
	output logic                             level_condition_probe_in
);
	import bebt_pkg::*;
	int gap = 2;
	initial begin
		{bus_valid, bus_addr, bus_write, bus_data, bus_type, bus_area} = '0;
		{probe_in, level_condition_probe_in} = '0;
	end
	// One bus cycle; gap of at least 2 lets halt settle before return
	task automatic cyc(input logic [ADDR_W-1:0] a, input logic w,
		input logic [DATA_W-1:0] d, input logic [1:0] t, input logic [1:0] ar);
		@(posedge pclk);
		bus_valid <= 1'b1;
		{bus_addr, bus_write, bus_data, bus_type, bus_area} <= {a, w, d, t, ar};
		@(posedge pclk);
		bus_valid <= 1'b0;
		// Idle bus shows junk so a stale value never passes for live
		{bus_addr, bus_write, bus_data, bus_type, bus_area} <= ~{a, w, d, t, ar};
		repeat (gap) @(posedge pclk);
	endtask : cyc
	// Probe levels, held long enough to cross the synchronisers
	task automatic probes(input logic [NPRB-1:0] p, input logic l);
		@(posedge pclk);
		probe_in <= p;
		level_condition_probe_in <= l;
		repeat (4) @(posedge pclk);
	endtask : probes
endmodule : bebt_mcu_model

// *** sim/testbench.sv ***
// Self-checking bench for bebt_top with an emulated MCU bus model.
// Assumes bebt_pkg, bebt_top, the model and the checker compiled first.
`timescale 1ns/1ps

module testbench;
	import bebt_pkg::*;
	localparam logic [CFG_W-1:0] CF_A = 20'hC0000;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic [PA_W-1:0]   paddr = '0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [31:0]       pwdata = '0;
	logic [31:0]       prdata;
	logic              pready, pslverr, bv, bw, lvl, mon, brk;
	logic [ADDR_W-1:0] ba;
	logic [DATA_W-1:0] bd;
	logic [1:0]        bt, bar;
	logic [NPRB-1:0]   prb;
	int                bad_count = 0, n_checks = 0, mon_cnt = 0;
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (mon === 1'b1) mon_cnt <= mon_cnt + 1;
	bebt_top bebt_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .bus_valid(bv), .bus_addr(ba), .bus_write(bw),
		.bus_data(bd), .bus_type(bt), .bus_area(bar), .probe_in(prb),
		.level_condition_probe_in(lvl), .monitor_trigger_probe_out(mon), .break_req(brk));
	bebt_mcu_model mdl (.pclk(pclk), .bus_valid(bv), .bus_addr(ba), .bus_write(bw),
		.bus_data(bd), .bus_type(bt), .bus_area(bar), .probe_in(prb),
		.level_condition_probe_in(lvl));
	// ----
	// Helpers
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [PA_W-1:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n == 50) bad_count++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [PA_W-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rdc(input logic [PA_W-1:0] a, input logic [31:0] d, input logic er);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		if (!er) chk(r, d);
		chk(32'(e), 32'(er));
	endtask : rdc
	function automatic logic [PA_W-1:0] cha(input int c, input logic [2:0] r);
		return CH_BASE + PA_W'(c * 32) + PA_W'({r, 2'b00});
	endfunction : cha
	task automatic setch(input int c, input logic [ADDR_W-1:0] lo, hi,
		input logic [CFG_W-1:0] cf, input logic [DLY_W-1:0] dl);
		wr(cha(c, CH_LO), 32'(lo));
		wr(cha(c, CH_HI), 32'(hi));
		wr(cha(c, CH_CFG), 32'(cf));
		wr(cha(c, CH_DLY), 32'(dl));
	endtask : setch
	// Disabled qualifiers always pass
	function automatic logic hit_exp(input logic [CFG_W-1:0] c, input logic [ADDR_W-1:0] lo,
		hi, a, input logic [DATA_W-1:0] dv, dm, d, input logic w, input logic [1:0] t, ar,
		input logic [NPRB-1:0] p, input logic l, pol);
		logic h;
		h = c[CFG_CH_EN];
		if (c[CFG_ADDR_EN] && (a < lo || a > hi)) h = 1'b0;
		if (c[1:0] == DIR_RD && w || c[1:0] == DIR_WR && !w || c[1:0] == 2'h3) h = 1'b0;
		if (c[CFG_DATA_EN] && ((d ^ dv) & dm) != '0) h = 1'b0;
		if (c[CFG_TYPE_EN] && t != c[5:4]) h = 1'b0;
		if (c[CFG_AREA_EN] && ar != c[8:7]) h = 1'b0;
		if (((p ^ c[16:13]) & c[12:9]) != '0) h = 1'b0;
		if (c[CFG_LVL_EN] && l != pol) h = 1'b0;
		return h;
	endfunction : hit_exp
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#200000;
		bad_count++;
		wrap_up();
	end
	// ----
	// Tests
	// ----
	initial begin
		logic [31:0] r;
		logic e, w, pol, lv, en;
		logic [1:0] t, ar;
		logic [CFG_W-1:0] cf;
		logic [ADDR_W-1:0] lo, hi, a;
		logic [DATA_W-1:0] dv, dm, d;
		logic [NPRB-1:0] p;
		void'($urandom(32'h0064));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(REG_CTRL, RST_WORD, 1'b0);
		rdc(REG_STAT, RST_WORD, 1'b0);
		wr(REG_STAT, 32'hFFFFFFFF);
		rdc(REG_STAT, RST_WORD, 1'b0);
		rdc(12'h098, 32'h0, 1'b1);
		rdc(12'h180, 32'h0, 1'b1);
		rdc(12'h002, 32'h0, 1'b1);
		$display("test reset done");
		for (int i = 0; i < NMON; i++) begin
			a = ADDR_W'($urandom);
			wr(MON_BASE + PA_W'(4 * i), 32'h80000000 | 32'(a));
			mdl.cyc(a, 1'b0, '0, '0, '0);
			mdl.cyc(a ^ 24'h1, 1'b1, '0, '0, '0);
			chk(32'(mon_cnt), 32'(i + 1));
		end
		$display("test monitor done");
		setch(0, 24'h1000, 24'h1000, CF_A | 20'h1, '0);
		setch(1, 24'h2000, 24'h2000, CF_A | 20'h2, '0);
		wr(REG_CTRL, 32'h30);
		mdl.cyc(24'h2000, 1'b1, '0, '0, '0);
		chk(32'(brk), 32'h0);
		mdl.cyc(24'h1000, 1'b0, '0, '0, '0);
		mdl.cyc(24'h1000, 1'b1, '0, '0, '0);
		chk(32'(brk), 32'h0);
		mdl.cyc(24'h2000, 1'b1, '0, '0, '0);
		chk(32'(brk), 32'h1);
		wr(REG_CTRL, 32'h100);
		$display("test sequence done");
		wr(REG_BDLY, 32'hFFFFFFFF);
		rdc(REG_BDLY, 32'(BDLY_MAX), 1'b0);
		setch(0, 24'h1000, 24'h1000, CF_A, 16'h3);
		wr(REG_BDLY, 32'h2);
		wr(REG_CTRL, 32'h1);
		mdl.cyc(24'h1000, 1'b0, '0, '0, '0);
		for (int i = 1; i <= 5; i++) begin
			mdl.cyc(24'h1001, 1'b0, '0, '0, '0);
			chk(32'(brk), 32'(i == 5));
		end
		wr(REG_CTRL, 32'h100);
		wr(REG_BDLY, 32'h0);
		$display("test delay done");
		setch(0, 24'h1000, 24'h1000, CF_A, '0);
		wr(REG_TSEL, 32'h4);
		wr(REG_CTRL, 32'h200);
		mdl.cyc(24'h1000, 1'b0, '0, '0, '0);
		repeat (10) @(posedge pclk);
		mdl.cyc(24'h2000, 1'b1, '0, '0, '0);
		apb(1'b0, REG_TMR, 32'h0, r, e);
		chk(r, 32'h0000_000E);
		apb(1'b0, REG_STAT, 32'h0, r, e);
		chk(r, 32'h0000_0008);
		$display("test timer done");
		for (int i = 0; i < 48; i++) begin
			cf = CFG_W'($urandom & $urandom);
			cf[CFG_CH_EN] = ($urandom % 4) != 0;
			lo = ADDR_W'($urandom) & 24'hFFFFF0;
			hi = lo + ADDR_W'($urandom % 3);
			a = lo + ADDR_W'($urandom % 4);
			dv = DATA_W'($urandom);
			dm = DATA_W'($urandom);
			d = dv ^ (DATA_W'($urandom) & 16'h0101);
			{w, t, ar, pol, lv, en} = 8'($urandom);
			p = NPRB'($urandom);
			setch(0, lo, hi, cf, '0);
			wr(cha(0, CH_DAT), 32'(dv));
			wr(cha(0, CH_MSK), 32'(dm));
			wr(REG_CTRL, {24'h0, pol, 6'h0, en});
			mdl.gap = 2 + ($urandom % 3);
			mdl.probes(p, lv);
			mdl.cyc(a, w, d, t, ar);
			en = en & hit_exp(cf, lo, hi, a, dv, dm, d, w, t, ar, p, lv, pol);
			chk(32'(brk), 32'(en));
			wr(REG_CTRL, 32'h100);
		end
		$display("test random done");
		wrap_up();
	end
endmodule : testbench
